// file: rtl/acq_regs_pkg.sv
// Shared offsets, field positions, reset values and states of the readout block
package acq_regs_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFS_RESULT_LO = 5'h00;
  localparam logic [4:0] OFS_RESULT_HI = 5'h01;
  localparam logic [4:0] OFS_RANGE = 5'h02;
  localparam logic [4:0] OFS_FIRST_CHAN = 5'h04;
  localparam logic [4:0] OFS_LAST_CHAN = 5'h05;
  localparam logic [4:0] OFS_CTRL_LO = 5'h06;
  localparam logic [4:0] OFS_CTRL_HI = 5'h07;
  localparam logic [4:0] OFS_IRQ_CLEAR = 5'h08;
  localparam logic [4:0] OFS_FIFO_CLEAR = 5'h09;
  localparam logic [4:0] OFS_AOUT0_LO = 5'h0a;
  localparam logic [4:0] OFS_AOUT0_HI = 5'h0b;
  localparam logic [4:0] OFS_AOUT1_LO = 5'h0c;
  localparam logic [4:0] OFS_AOUT1_HI = 5'h0d;
  localparam logic [4:0] OFS_AOUT_CTRL_LO = 5'h0e;
  localparam logic [4:0] OFS_AOUT_CTRL_HI = 5'h0f;
  localparam logic [4:0] OFS_DOUT_LO = 5'h10;
  localparam logic [4:0] OFS_DOUT_HI = 5'h11;
  localparam logic [4:0] OFS_CAL_DATA = 5'h12;
  localparam logic [4:0] OFS_CAL_CMD = 5'h13;
  localparam logic [4:0] OFS_COUNTER_ZERO = 5'h18;
  localparam logic [4:0] OFS_COUNTER_ONE = 5'h1a;
  localparam logic [4:0] OFS_COUNTER_TWO = 5'h1c;
  localparam logic [4:0] OFS_COUNTER_MODE = 5'h1e;
  // Control low byte fields
  localparam int unsigned SOFT_TRIGGER_SELECT_BIT = 0;
  localparam int unsigned PACER_SELECT_BIT = 1;
  localparam int unsigned EXT_TRIGGER_SELECT_BIT = 2;
  localparam int unsigned GATE_BIT = 3;
  localparam int unsigned IRQ_ALLOW_BIT = 4;
  localparam int unsigned IRQ_PER_SAMPLE_OR_HALF_BIT = 5;
  localparam int unsigned PACER_CLOCK_SELECT_BIT = 6;
  localparam int unsigned RESULT_WIDTH_FLAG_BIT = 7;
  // Result byte layout for the twelve-bit variant
  localparam int unsigned CHAN_NUM_LOW_BIT = 4;
  localparam int unsigned CHAN_NUM_TOP_BIT = 7;
  localparam int unsigned RESULT12_HI_TOP = 3;
  localparam int unsigned RESULT12_MSB = 11;
  localparam int unsigned RESULT12_HI_LSB = 8;
  localparam int unsigned CAL_CMD_TOP_BIT = 3;
  localparam int unsigned CHAN_W = 4;
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [3:0] RESET_CHAN = 4'h0;
  localparam logic [15:0] RESET_PACER_DIV = 16'h0000;
  // Conversion sequencer states, Gray coded
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_BUSY = 2'b01
  } conv_state_type;
endpackage

// file: rtl/scan_channel_seq.sv
// Input multiplexer scan pointer from first to last channel with wrap
`timescale 1ns/1ps
`default_nettype none
module scan_channel_seq
  import acq_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] first_chan,
  input wire logic [3:0] last_chan,
  input wire logic reload,
  input wire logic advance,
  output logic [3:0] chan
);
  logic [3:0] next_chan;
  wire at_last = (chan == last_chan);
  // Natural 4-bit wrap lets a window such as 13..2 pass through 15 and 0
  wire [3:0] step_chan = 4'(chan + 4'h1);

  always_comb begin
    next_chan = chan;
    if (reload) begin
      next_chan = first_chan;
    end else if (advance) begin
      next_chan = at_last ? first_chan : step_chan;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      chan <= RESET_CHAN;
    end else begin
      chan <= next_chan;
    end
  end
endmodule // scan_channel_seq
`default_nettype wire

// file: rtl/acq_card_adc_readout_regs.sv
// Byte-wide host register block: conversion readout, trigger and output ports
//
// Notes on behaviour
// - Twelve-bit: low byte offset 0, nibble offset 1.
// - Twelve-bit: channel number in offset 1 top nibble.
// - Twelve-bit result bit 0 is LSB, 11 MSB.
// - Sixteen-bit: offset 1 holds upper byte, no channel.
// - Sixteen-bit result bit 0 LSB, 15 MSB.
// - Calibration command nibble offset 19, data offset 18.
// - Channel number belongs to the returned result.
// - Software trigger: any write to offset 0 converts; this block does so only with control bit 0 set and while idle.
// - Control bits 2..0 choose the trigger source.
// - Each trigger taken while idle advances scan, wrapping last to first.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module acq_card_adc_readout_regs
  import acq_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  // Host register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Converter side, same clock
  output logic conv_start,
  output logic [3:0] conv_chan,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  // External trigger pin, asynchronous
  input wire logic ext_trigger_pin,
  // Configuration and output ports
  output logic [7:0] input_range_setting,
  output logic range_load,
  output logic [3:0] range_chan,
  output logic [15:0] conversion_control,
  output logic irq_clear,
  output logic fifo_clear,
  output logic [15:0] analog_out0_value,
  output logic [15:0] analog_out1_value,
  output logic [15:0] analog_out_control,
  output logic [15:0] digital_out_port,
  output logic [7:0] cal_data,
  output logic [3:0] cal_cmd,
  output logic cal_strobe,
  output logic [7:0] counter_mode_control
);
  // Write decode, one wire per port
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_result = reg_wr && hit(reg_addr, OFS_RESULT_LO);
  wire wr_range = reg_wr && hit(reg_addr, OFS_RANGE);
  wire wr_first = reg_wr && hit(reg_addr, OFS_FIRST_CHAN);
  wire wr_last = reg_wr && hit(reg_addr, OFS_LAST_CHAN);
  wire wr_ctrl_lo = reg_wr && hit(reg_addr, OFS_CTRL_LO);
  wire wr_ctrl_hi = reg_wr && hit(reg_addr, OFS_CTRL_HI);
  wire wr_irq_clr = reg_wr && hit(reg_addr, OFS_IRQ_CLEAR);
  wire wr_fifo_clr = reg_wr && hit(reg_addr, OFS_FIFO_CLEAR);
  wire wr_a0_lo = reg_wr && hit(reg_addr, OFS_AOUT0_LO);
  wire wr_a0_hi = reg_wr && hit(reg_addr, OFS_AOUT0_HI);
  wire wr_a1_lo = reg_wr && hit(reg_addr, OFS_AOUT1_LO);
  wire wr_a1_hi = reg_wr && hit(reg_addr, OFS_AOUT1_HI);
  wire wr_ac_lo = reg_wr && hit(reg_addr, OFS_AOUT_CTRL_LO);
  wire wr_ac_hi = reg_wr && hit(reg_addr, OFS_AOUT_CTRL_HI);
  wire wr_do_lo = reg_wr && hit(reg_addr, OFS_DOUT_LO);
  wire wr_do_hi = reg_wr && hit(reg_addr, OFS_DOUT_HI);
  wire wr_cal_data = reg_wr && hit(reg_addr, OFS_CAL_DATA);
  wire wr_cal_cmd = reg_wr && hit(reg_addr, OFS_CAL_CMD);
  wire wr_pacer_clock_select = reg_wr && hit(reg_addr, OFS_COUNTER_ZERO);
  wire wr_cnt1 = reg_wr && hit(reg_addr, OFS_COUNTER_ONE);
  wire wr_cnt2 = reg_wr && hit(reg_addr, OFS_COUNTER_TWO);
  wire wr_cmode = reg_wr && hit(reg_addr, OFS_COUNTER_MODE);
  wire rd_result_lo = reg_rd && hit(reg_addr, OFS_RESULT_LO);

  // Stored configuration
  logic [3:0] first_chan;
  logic [3:0] last_chan;
  logic [7:0] counter_zero;
  logic [7:0] counter_one;
  logic [7:0] counter_two;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      first_chan <= RESET_CHAN;
      last_chan <= RESET_CHAN;
      input_range_setting <= RESET_BYTE;
      conversion_control <= RESET_WORD;
      counter_mode_control <= RESET_BYTE;
      cal_data <= RESET_BYTE;
      cal_cmd <= RESET_CHAN;
    end else begin
      if (wr_first) begin
        first_chan <= reg_wdata[CHAN_W-1:0];
      end
      if (wr_last) begin
        last_chan <= reg_wdata[CHAN_W-1:0];
      end
      if (wr_range) begin
        input_range_setting <= reg_wdata;
      end
      if (wr_ctrl_lo) begin
        conversion_control[7:0] <= reg_wdata;
      end
      if (wr_ctrl_hi) begin
        conversion_control[15:8] <= reg_wdata;
      end
      if (wr_cmode) begin
        counter_mode_control <= reg_wdata;
      end
      if (wr_cal_data) begin
        cal_data <= reg_wdata;
      end
      if (wr_cal_cmd) begin
        cal_cmd <= reg_wdata[CAL_CMD_TOP_BIT:0];
      end
    end
  end

  // Word-wide output ports, byte lanes written separately
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      analog_out0_value <= RESET_WORD;
      analog_out1_value <= RESET_WORD;
      analog_out_control <= RESET_WORD;
      digital_out_port <= RESET_WORD;
    end else begin
      if (wr_a0_lo) begin
        analog_out0_value[7:0] <= reg_wdata;
      end
      if (wr_a0_hi) begin
        analog_out0_value[15:8] <= reg_wdata;
      end
      if (wr_a1_lo) begin
        analog_out1_value[7:0] <= reg_wdata;
      end
      if (wr_a1_hi) begin
        analog_out1_value[15:8] <= reg_wdata;
      end
      if (wr_ac_lo) begin
        analog_out_control[7:0] <= reg_wdata;
      end
      if (wr_ac_hi) begin
        analog_out_control[15:8] <= reg_wdata;
      end
      if (wr_do_lo) begin
        digital_out_port[7:0] <= reg_wdata;
      end
      if (wr_do_hi) begin
        digital_out_port[15:8] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      counter_zero <= RESET_BYTE;
      counter_one <= RESET_BYTE;
      counter_two <= RESET_BYTE;
    end else begin
      if (wr_pacer_clock_select) begin
        counter_zero <= reg_wdata;
      end
      if (wr_cnt1) begin
        counter_one <= reg_wdata;
      end
      if (wr_cnt2) begin
        counter_two <= reg_wdata;
      end
    end
  end

  // One-cycle command pulses
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_clear <= 1'b0;
      fifo_clear <= 1'b0;
      cal_strobe <= 1'b0;
      range_load <= 1'b0;
    end else begin
      irq_clear <= wr_irq_clr;
      fifo_clear <= wr_fifo_clr;
      cal_strobe <= wr_cal_cmd;
      range_load <= wr_range;
    end
  end

  // Gain codes are filed under the first scan channel
  assign range_chan = first_chan;

  // External trigger pin: two flops, then edge detect on the second
  // Pin idles low, so the detector resets low and no false edge follows reset
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_trigger_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  wire ext_rise = ext_sync && !ext_prev;

  // Pacer: counters one and zero form the divisor; zero stops it
  // A new divisor takes effect after the running period ends
  logic [15:0] pacer_count;
  wire [15:0] pacer_div = {counter_one, counter_zero};
  wire pacer_on = conversion_control[PACER_SELECT_BIT] && (pacer_div != RESET_PACER_DIV);
  wire pacer_tick = pacer_on && (pacer_count == RESET_PACER_DIV);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pacer_count <= RESET_PACER_DIV;
    end else if (!pacer_on || pacer_tick) begin
      pacer_count <= pacer_on ? 16'(pacer_div - 16'h0001) : RESET_PACER_DIV;
    end else begin
      pacer_count <= 16'(pacer_count - 16'h0001);
    end
  end

  // Trigger source selection
  wire soft_trig = wr_result && conversion_control[SOFT_TRIGGER_SELECT_BIT];
  wire ext_trig = ext_rise && conversion_control[EXT_TRIGGER_SELECT_BIT];
  wire any_trig = soft_trig || ext_trig || pacer_tick;

  // Conversion sequencer; triggers during a conversion are dropped
  conv_state_type state;
  conv_state_type next_state;
  wire take_trig = (state == CONV_IDLE) && any_trig;
  wire scan_reload = wr_first || wr_last;
  logic [3:0] scan_chan;
  // Reload takes the first channel being written, not the stale one
  wire [3:0] reload_first = wr_first ? reg_wdata[CHAN_W-1:0] : first_chan;

  // Dropping triggers while busy keeps each result paired with one channel
  scan_channel_seq u_scan (
    .mclk(mclk),
    .rstn(rstn),
    .first_chan(reload_first),
    .last_chan(last_chan),
    .reload(scan_reload),
    .advance(take_trig),
    .chan(scan_chan)
  );

  always_comb begin
    case (state)
      CONV_IDLE: begin
        next_state = take_trig ? CONV_BUSY : CONV_IDLE;
      end
      CONV_BUSY: begin
        next_state = conv_done ? CONV_IDLE : CONV_BUSY;
      end
      default: begin
        next_state = CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= CONV_IDLE;
      conv_start <= 1'b0;
      conv_chan <= RESET_CHAN;
    end else begin
      state <= next_state;
      conv_start <= take_trig;
      if (take_trig) begin
        conv_chan <= scan_chan;
      end
    end
  end

  // Latest result with the channel it was taken from
  logic [15:0] result_word;
  logic [3:0] result_chan;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result_word <= RESET_WORD;
      result_chan <= RESET_CHAN;
    end else if (conv_done && state == CONV_BUSY) begin
      result_word <= conv_data;
      result_chan <= conv_chan;
    end
  end

  // Reading the low byte freezes the high byte, so a low-then-high
  // pair never straddles two samples even if a new one lands between
  logic [7:0] held_hi;
  wire wide_mode = conversion_control[RESULT_WIDTH_FLAG_BIT];
  // Width mode is taken at freeze time; switching it between the two reads is not supported
  wire [7:0] hi12 = {result_chan, result_word[RESULT12_MSB:RESULT12_HI_LSB]};
  wire [7:0] hi_now = wide_mode ? result_word[15:8] : hi12;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      held_hi <= RESET_BYTE;
    end else if (rd_result_lo) begin
      held_hi <= hi_now;
    end
  end

  // Read mux; unmapped and write-only offsets read as zero
  // Counters read back the last byte written; there is no live count here
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = RESET_BYTE;
    case (reg_addr)
      OFS_RESULT_LO: next_rdata = result_word[7:0];
      OFS_RESULT_HI: next_rdata = held_hi;
      OFS_DOUT_LO: next_rdata = digital_out_port[7:0];
      OFS_DOUT_HI: next_rdata = digital_out_port[15:8];
      OFS_COUNTER_ZERO: next_rdata = counter_zero;
      OFS_COUNTER_ONE: next_rdata = counter_one;
      OFS_COUNTER_TWO: next_rdata = counter_two;
      default: next_rdata = RESET_BYTE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= RESET_BYTE;
    end else begin
      // Data fall back to zero after one cycle so a stale byte is never taken
      reg_rdata <= reg_rd ? next_rdata : RESET_BYTE;
    end
  end
endmodule // acq_card_adc_readout_regs
`default_nettype wire

// file: test/acq_chk.sv
// Assertion checker for the readout register block
`timescale 1ns/1ps
`default_nettype none
module acq_chk
  import acq_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_start,
  input wire logic [3:0] conv_chan,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  input wire logic [15:0] conversion_control,
  input wire logic [7:0] cal_data,
  input wire logic [3:0] cal_cmd,
  input wire logic cal_strobe
);
  logic busy;
  logic [15:0] res, frz;
  logic [3:0] rch, fch, first, last, ptr;
  wire rd0 = reg_rd && reg_addr == OFS_RESULT_LO;
  wire rd1 = reg_rd && reg_addr == OFS_RESULT_HI;
  wire w16 = conversion_control[RESULT_WIDTH_FLAG_BIT];
  wire [7:0] hi12 = {fch, frz[11:8]};
  wire [7:0] hi16 = frz[15:8];
  wire [7:0] lo8 = res[7:0];
  // Shadow of the captured sample and the scan pointer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      {res, frz, rch, fch, first, last, ptr} <= '0;
    end else begin
      busy <= conv_start | (busy & ~conv_done);
      if (conv_done && busy) {res, rch} <= {conv_data, conv_chan};
      if (rd0) {frz, fch} <= {res, rch};
      if (reg_wr && reg_addr == OFS_FIRST_CHAN) {first, ptr} <= {reg_wdata[3:0], reg_wdata[3:0]};
      else if (reg_wr && reg_addr == OFS_LAST_CHAN) {last, ptr} <= {reg_wdata[3:0], first};
      else if (conv_start) ptr <= (ptr == last) ? first : ptr + 4'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_lo; rd0 |=> reg_rdata == $past(lo8); endproperty
  a_lo: assert property (p_lo) else $error("low result byte wrong");
  property p_hi12; rd1 && !w16 |=> reg_rdata == $past(hi12); endproperty
  a_hi12: assert property (p_hi12) else $error("channel and high nibble wrong");
  property p_hi16; rd1 && w16 |=> reg_rdata == $past(hi16); endproperty
  a_hi16: assert property (p_hi16) else $error("upper result byte wrong");
  property p_start;
    reg_wr && reg_addr == OFS_RESULT_LO && conversion_control[SOFT_TRIGGER_SELECT_BIT] && !busy && !conv_start
      |=> conv_start;
  endproperty
  a_start: assert property (p_start) else $error("soft trigger did not start");
  property p_busy; conv_start |-> !busy; endproperty
  a_busy: assert property (p_busy) else $error("start while converting");
  property p_scan; conv_start |-> conv_chan == ptr; endproperty
  a_scan: assert property (p_scan) else $error("scan channel out of order");
  property p_cal; reg_wr && reg_addr == OFS_CAL_CMD |=> cal_strobe && {4'h0, cal_cmd} == ($past(reg_wdata) & 8'h0f);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration command wrong");
  property p_cald; reg_wr && reg_addr == OFS_CAL_DATA |=> !cal_strobe && cal_data == $past(reg_wdata); endproperty
  a_cald: assert property (p_cald) else $error("calibration data wrong");
endmodule // acq_chk
bind acq_card_adc_readout_regs acq_chk acq_chk_inst (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
  .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data), .conversion_control(conversion_control),
  .cal_data(cal_data), .cal_cmd(cal_cmd), .cal_strobe(cal_strobe));
`default_nettype wire

// file: test/adc_conv_model.sv
// Converter model answering each start after a random delay
`timescale 1ns/1ps
`default_nettype none
module adc_conv_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic conv_start,
  output logic conv_done,
  output logic [15:0] conv_data
);
  int wait_n;
  logic [15:0] val;
  // Data toggles outside the done cycle so a late capture is caught
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wait_n <= 0;
      conv_done <= 1'b0;
      conv_data <= 16'hffff;
    end else begin
      conv_done <= (wait_n == 1);
      conv_data <= (wait_n == 1) ? val : ~conv_data;
      if (conv_start) begin
        wait_n <= 1 + $urandom % 6;
        val <= 16'($urandom);
      end else if (wait_n > 0) begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule // adc_conv_model
`default_nettype wire

// file: test/test_acq_card_adc_readout_regs.sv
// Self-checking bench for the readout register block
`timescale 1ns/1ps
`default_nettype none
module test_acq_card_adc_readout_regs
  import acq_regs_pkg::*;
;
  logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ext_trigger_pin = 1'b0, rd_d = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic conv_start, conv_done;
  logic [15:0] conv_data, smp, old;
  logic [3:0] conv_chan, ptr, chn, rc;
  logic [7:0] rng, cmode;
  logic [15:0] a0, a1, ac;
  logic rl, ic, fc;
  logic [7:0] q[$];
  int err_total = 0;
  int n_tests = 0;
  always #20 mclk = ~mclk;
  acq_card_adc_readout_regs acq_card_adc_readout_regs_inst (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
    .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data), .ext_trigger_pin(ext_trigger_pin),
    .input_range_setting(rng), .range_load(rl), .range_chan(rc), .conversion_control(), .irq_clear(ic),
    .fifo_clear(fc), .analog_out0_value(a0), .analog_out1_value(a1), .analog_out_control(ac),
    .digital_out_port(), .cal_data(), .cal_cmd(), .cal_strobe(), .counter_mode_control(cmode));
  adc_conv_model adc_conv_model_inst (.mclk(mclk), .rstn(rstn), .conv_start(conv_start),
    .conv_done(conv_done), .conv_data(conv_data));
  task automatic test_done;
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One idle cycle between strobes keeps each strobe a clean pulse
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    q.push_back(v);
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic wait_done;
    int i;
    for (i = 0; i < 200; i++) begin
      @(negedge mclk);
      if (conv_done === 1'b1) break;
    end
    if (i == 200) begin
      err_total++;
      test_done();
    end
    old = smp;
    smp = conv_data;
    chn = ptr;
    ptr = (ptr == 4'h2) ? 4'hd : ptr + 4'h1;
  endtask
  always @(posedge mclk) begin
    rd_d <= reg_rd;
    if (rd_d) check(reg_rdata, q.pop_front(), "read data");
  end
  initial begin
    void'($urandom(32'h961a));
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    wr(OFS_CTRL_LO, 8'h01);
    wr(OFS_FIRST_CHAN, 8'h0d);
    wr(OFS_LAST_CHAN, 8'h02);
    ptr = 4'hd;
    // Window 13 to 2 crosses the 15 to 0 wrap and the last to first wrap
    repeat (7) begin
      wr(OFS_RESULT_LO, 8'($urandom));
      wait_done();
      rd(OFS_RESULT_LO, smp[7:0]);
      rd(OFS_RESULT_HI, {chn, smp[11:8]});
    end
    wr(OFS_CTRL_LO, 8'h81);
    wr(OFS_RESULT_LO, 8'h00);
    wait_done();
    rd(OFS_RESULT_LO, smp[7:0]);
    wr(OFS_RESULT_LO, 8'h00);
    wait_done();
    rd(OFS_RESULT_HI, old[15:8]);
    rd(OFS_RESULT_LO, smp[7:0]);
    rd(OFS_RESULT_HI, smp[15:8]);
    d = 8'($urandom);
    wr(OFS_CAL_DATA, d);
    wr(OFS_CAL_CMD, d);
    rd(OFS_CAL_CMD, 8'h00);
    wr(OFS_DOUT_LO, d);
    rd(OFS_DOUT_LO, d);
    rd(5'h15, 8'h00);
    // Range code is filed under the first scan channel, 13 here
    wr(OFS_RANGE, d);
    @(negedge mclk);
    check(rng, d, "range setting");
    check({3'h0, rl, rc}, 8'h1d, "range load and channel");
    wr(OFS_IRQ_CLEAR, d);
    @(negedge mclk);
    check({6'h0, ic, fc}, 8'h02, "irq clear pulse");
    wr(OFS_FIFO_CLEAR, d);
    @(negedge mclk);
    check({6'h0, ic, fc}, 8'h01, "fifo clear pulse");
    wr(OFS_AOUT0_LO, d);
    wr(OFS_AOUT0_HI, ~d);
    wr(OFS_AOUT1_HI, d);
    wr(OFS_AOUT_CTRL_HI, ~d);
    wr(OFS_COUNTER_MODE, d);
    @(negedge mclk);
    check(a0[7:0], d, "analog out 0 low");
    check(a0[15:8], ~d, "analog out 0 high");
    check(a1[15:8], d, "analog out 1 high");
    check(a1[7:0], 8'h00, "analog out 1 low");
    check(ac[15:8], ~d, "analog out control high");
    check(cmode, d, "counter mode");
    wr(OFS_CTRL_LO, 8'h04);
    ext_trigger_pin <= 1'b1;
    wait_done();
    @(posedge mclk);
    ext_trigger_pin <= 1'b0;
    rd(OFS_RESULT_LO, smp[7:0]);
    rd(OFS_RESULT_HI, {chn, smp[11:8]});
    wr(OFS_COUNTER_ZERO, 8'h03);
    rd(OFS_COUNTER_ZERO, 8'h03);
    wr(OFS_CTRL_LO, 8'h02);
    wait_done();
    wr(OFS_CTRL_LO, 8'h00);
    repeat (20) @(posedge mclk);
    test_done();
  end
endmodule // test_acq_card_adc_readout_regs
`default_nettype wire
